// >>> sic_pkg.sv
// Shared constants, field layouts and carrier types of the synthesizer control block
package sic_pkg;

  localparam int WORD_W = 24;
  localparam int ADDR_W = 3;

  // Word addresses in the low three bits of each serial word
  localparam logic [2:0] ADDR_RF_FREQ_A  = 3'h0;
  localparam logic [2:0] ADDR_RF_FREQ_B  = 3'h1;
  localparam logic [2:0] ADDR_RF_CONTROL = 3'h2;
  localparam logic [2:0] ADDR_MASTER     = 3'h3;
  localparam logic [2:0] ADDR_IF_N_DIV   = 3'h4;
  localparam logic [2:0] ADDR_IF_REF_DIV = 3'h5;
  localparam logic [2:0] ADDR_IF_CONTROL = 3'h6;
  localparam int         NUM_WORDS       = 7;

  localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;

  // IF control word fields
  localparam int IF_CNT_RST_BIT  = 3;
  localparam int IF_CP_HIZ_BIT   = 4;
  localparam int IF_PWR_DN_BIT   = 5;
  localparam int IF_POLARITY_BIT = 7;
  localparam int IF_CP_CUR_LSB   = 8;
  localparam int IF_CP_CUR_W     = 3;
  localparam int IF_RESYNC_LO    = 11;
  localparam int IF_TEST_LSB     = 12;
  localparam int IF_TEST_W       = 2;
  localparam int IF_RESYNC_MID   = 14;
  localparam int IF_RESYNC_HI    = 15;

  // IF reference divider word: delay / IF ref count and doubler
  localparam int IF_REF_LSB      = 3;
  localparam int IF_REF_W        = 15;
  localparam int IF_DBL_BIT      = 18;

  // IF N divider word
  localparam int IF_A_LSB        = 3;
  localparam int IF_A_W          = 6;
  localparam int IF_B_LSB        = 9;
  localparam int IF_B_W          = 12;
  localparam int IF_P_LSB        = 21;
  localparam int IF_P_W          = 2;
  localparam int IF_N_W          = 19;

  // RF frequency words
  localparam int RF_FRAC_LSB     = 3;
  localparam int RF_FRAC_W       = 12;
  localparam int RF_INT_LSB      = 15;
  localparam int RF_INT_W        = 8;
  localparam int RF_MOD_LSB      = 3;
  localparam int RF_MOD_W        = 12;
  localparam int RF_R_LSB        = 15;
  localparam int RF_R_W          = 4;
  localparam int RF_DBL_BIT      = 19;

  typedef struct packed {
    logic sclk;
    logic sdata;
    logic latch_strobe;
  } sic_serial_t;

  typedef struct packed {
    logic                   cp_hiz;
    logic                   counter_load;
    logic                   lock_detect_reset;
    logic                   input_debias;
    logic                   powered_down;
    logic                   pd_positive;
    logic [IF_CP_CUR_W-1:0] cp_current;
    logic [IF_TEST_W-1:0]   test_mode;
  } sic_if_ctrl_t;

  typedef enum logic [0:0] {
    SIC_IDLE,
    SIC_WAIT
  } sic_resync_state_t;

  // Total IF division: prescaler modulus (8 << sel) times B plus A
  function automatic logic [IF_N_W-1:0] sic_if_n_total(input logic [IF_P_W-1:0] sel,
                                                       input logic [IF_B_W-1:0] b,
                                                       input logic [IF_A_W-1:0] a);
    logic [IF_N_W-1:0] prod;
    prod = {7'h00, b} << (5'h3 + {3'h0, sel});
    return prod + {13'h0000, a};
  endfunction

endpackage

// >>> sic_resync_timer.sv
// Delay timer that issues one resync pulse a programmed number of reference edges (one when programmed to zero) after a trigger
`timescale 1ns/10ps
module sic_resync_timer
  import sic_pkg::*;
#(
  parameter int DELAY_W = 15
) (
  input  wire logic               clk,
  input  wire logic               rstn,
  input  wire logic               enable,
  input  wire logic               trigger,
  input  wire logic               ref_tick,
  input  wire logic [DELAY_W-1:0] delay,
  output logic                    pulse
);
  import sic_pkg::*;

  sic_resync_state_t  state_q, state_d;
  logic [DELAY_W-1:0] count_q, count_d;
  logic               pulse_d;

  wire [DELAY_W-1:0] target   = (delay == '0) ? {{(DELAY_W-1){1'b0}}, 1'b1} : delay;
  wire [DELAY_W-1:0] count_nx = count_q + {{(DELAY_W-1){1'b0}}, 1'b1};
  wire               done     = (state_q == SIC_WAIT) && ref_tick && (count_nx == target);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    pulse_d = 1'b0;
    if (!enable) begin
      state_d = SIC_IDLE;
    end else if (trigger) begin
      // Retrigger restarts the interval
      state_d = SIC_WAIT;
      count_d = '0;
    end else begin
      unique case (state_q)
        SIC_IDLE: begin
        end
        SIC_WAIT: begin
          if (done) begin
            pulse_d = 1'b1;
            state_d = SIC_IDLE;
          end else if (ref_tick) begin
            count_d = count_nx;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SIC_IDLE;
      count_q <= '0;
      pulse   <= 1'b0;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
      pulse   <= pulse_d;
    end
  end

  // Helper count of reference edges since the last trigger
  logic [DELAY_W:0] seen_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      seen_q <= '0;
    end else if (trigger) begin
      seen_q <= '0;
    end else if (ref_tick && state_q == SIC_WAIT) begin
      seen_q <= seen_q + {{DELAY_W{1'b0}}, 1'b1};
    end
  end

  delay_count_a: assert property (@(posedge clk) disable iff (!rstn)
    $rose(pulse) |-> seen_q == {1'b0, $past(target)})
    else $error("resync pulse not at programmed delay");

endmodule

// >>> sic_synth_ctrl.sv
// Serial-programmed control words, IF control decode and RF phase resync of the synthesizer
`timescale 1ns/10ps
module sic_synth_ctrl
  import sic_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rstn,
  input  wire sic_pkg::sic_serial_t    serial,
  input  wire logic                    reference_input,
  output sic_pkg::sic_if_ctrl_t        if_ctrl,
  output logic                         resync_enable,
  output logic                         resync_pulse,
  output logic [sic_pkg::RF_INT_W-1:0] rf_int,
  output logic [sic_pkg::RF_FRAC_W-1:0] rf_frac,
  output logic [sic_pkg::RF_MOD_W-1:0] fractional_modulus,
  output logic [sic_pkg::RF_R_W-1:0]   rf_ref_div,
  output logic                         rf_ref_doubler,
  output logic [sic_pkg::IF_REF_W-1:0] if_ref_div,
  output logic                         if_ref_doubler,
  output logic [sic_pkg::IF_N_W-1:0]   if_n_total,
  output logic [sic_pkg::WORD_W-1:0]   master_config_word,
  output logic [sic_pkg::WORD_W-1:0]   rf_control_word
);
  import sic_pkg::*;

  // Edge detection on the serial pins and the reference input
  logic              sclk_q;
  logic              strobe_q;
  logic              ref_q;
  logic [WORD_W-1:0] shift_q;

  wire sclk_rise   = serial.sclk & ~sclk_q;
  wire strobe_rise = serial.latch_strobe & ~strobe_q;
  wire ref_tick    = reference_input & ~ref_q;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_q   <= 1'b0;
      strobe_q <= 1'b0;
      ref_q    <= 1'b0;
    end else begin
      sclk_q   <= serial.sclk;
      strobe_q <= serial.latch_strobe;
      ref_q    <= reference_input;
    end
  end

  // Most significant bit first; the last 24 bits before the strobe count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift_q <= WORD_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_W-2:0], serial.sdata};
    end
  end

  // Latch decode; power-down does not gate it
  wire [ADDR_W-1:0] addr     = shift_q[ADDR_W-1:0];
  wire              ld_rf_a  = strobe_rise && (addr == ADDR_RF_FREQ_A);
  wire              ld_rf_b  = strobe_rise && (addr == ADDR_RF_FREQ_B);
  wire              ld_rfc   = strobe_rise && (addr == ADDR_RF_CONTROL);
  wire              ld_mst   = strobe_rise && (addr == ADDR_MASTER);
  wire              ld_ifn   = strobe_rise && (addr == ADDR_IF_N_DIV);
  wire              ld_ifr   = strobe_rise && (addr == ADDR_IF_REF_DIV);
  wire              ld_ifc   = strobe_rise && (addr == ADDR_IF_CONTROL);

  logic [WORD_W-1:0] words_q [NUM_WORDS];

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_WORDS; i++) begin
        words_q[i] <= WORD_RESET;
      end
    end else if (strobe_rise && addr != 3'h7) begin
      words_q[addr] <= shift_q;
    end
  end

  wire [WORD_W-1:0] rf_freq_word_a       = words_q[ADDR_RF_FREQ_A];
  wire [WORD_W-1:0] rf_freq_word_b       = words_q[ADDR_RF_FREQ_B];
  wire [WORD_W-1:0] if_n_divider_word    = words_q[ADDR_IF_N_DIV];
  wire [WORD_W-1:0] if_ref_divider_word  = words_q[ADDR_IF_REF_DIV];
  wire [WORD_W-1:0] if_control_setup     = words_q[ADDR_IF_CONTROL];

  // IF control decode; power-down forces its side effects
  wire pd_d       = if_control_setup[IF_PWR_DN_BIT];
  wire cp_hiz_d   = if_control_setup[IF_CP_HIZ_BIT] | pd_d;
  wire cnt_load_d = if_control_setup[IF_CNT_RST_BIT] | pd_d;
  wire resync_d   = if_control_setup[IF_RESYNC_HI] & if_control_setup[IF_RESYNC_MID]
                    & if_control_setup[IF_RESYNC_LO];

  sic_if_ctrl_t ctrl_d;
  assign ctrl_d.cp_hiz            = cp_hiz_d;
  assign ctrl_d.counter_load      = cnt_load_d;
  assign ctrl_d.lock_detect_reset = pd_d;
  assign ctrl_d.input_debias      = pd_d;
  assign ctrl_d.powered_down      = pd_d;
  assign ctrl_d.pd_positive       = if_control_setup[IF_POLARITY_BIT];
  assign ctrl_d.cp_current        = if_control_setup[IF_CP_CUR_LSB +: IF_CP_CUR_W];
  assign ctrl_d.test_mode         = if_control_setup[IF_TEST_LSB +: IF_TEST_W];

  // Divider settings for the two loops
  wire [RF_INT_W-1:0]  rf_int_d  = rf_freq_word_a[RF_INT_LSB +: RF_INT_W];
  wire [RF_FRAC_W-1:0] rf_frac_d = rf_freq_word_a[RF_FRAC_LSB +: RF_FRAC_W];
  wire [RF_MOD_W-1:0]  rf_mod_d  = rf_freq_word_b[RF_MOD_LSB +: RF_MOD_W];
  wire [RF_R_W-1:0]    rf_r_d    = rf_freq_word_b[RF_R_LSB +: RF_R_W];
  wire                 rf_dbl_d  = rf_freq_word_b[RF_DBL_BIT];
  // One field serves both the resync delay and the IF comparator divide
  wire [IF_REF_W-1:0]  if_ref_d  = if_ref_divider_word[IF_REF_LSB +: IF_REF_W];
  wire [IF_N_W-1:0]    if_n_d    = sic_if_n_total(if_n_divider_word[IF_P_LSB +: IF_P_W],
                                                  if_n_divider_word[IF_B_LSB +: IF_B_W],
                                                  if_n_divider_word[IF_A_LSB +: IF_A_W]);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      if_ctrl            <= '0;
      resync_enable      <= 1'b0;
      rf_int             <= '0;
      rf_frac            <= '0;
      fractional_modulus <= '0;
      rf_ref_div         <= '0;
      rf_ref_doubler     <= 1'b0;
      if_ref_div         <= '0;
      if_ref_doubler     <= 1'b0;
      if_n_total         <= '0;
      master_config_word <= WORD_RESET;
      rf_control_word    <= WORD_RESET;
    end else begin
      if_ctrl            <= ctrl_d;
      resync_enable      <= resync_d;
      rf_int             <= rf_int_d;
      rf_frac            <= rf_frac_d;
      fractional_modulus <= rf_mod_d;
      rf_ref_div         <= rf_r_d;
      rf_ref_doubler     <= rf_dbl_d;
      if_ref_div         <= if_ref_d;
      if_ref_doubler     <= if_ref_divider_word[IF_DBL_BIT];
      if_n_total         <= if_n_d;
      master_config_word <= words_q[ADDR_MASTER];
      rf_control_word    <= words_q[ADDR_RF_CONTROL];
    end
  end

  // A write of either RF frequency word starts the resync interval while resync is enabled
  wire resync_trig = resync_d && (ld_rf_a || ld_rf_b);

  sic_resync_timer #(
    .DELAY_W (IF_REF_W)
  ) u_timer (
    .clk      (clk),
    .rstn     (rstn),
    .enable   (resync_d),
    .trigger  (resync_trig),
    .ref_tick (ref_tick),
    .delay    (if_ref_d),
    .pulse    (resync_pulse)
  );

  // Checks on the control decode and resync path
  cp_tristate_a: assert property (@(posedge clk) disable iff (!rstn)
    (ld_ifc && shift_q[IF_CP_HIZ_BIT]) |=> ##1 if_ctrl.cp_hiz)
    else $error("IF pump not floated after tri-state write");

  pd_restore_a: assert property (@(posedge clk) disable iff (!rstn)
    (ld_ifc && !shift_q[IF_PWR_DN_BIT] && !shift_q[IF_CP_HIZ_BIT]) |=> ##1
      (!if_ctrl.powered_down && !if_ctrl.cp_hiz && !if_ctrl.input_debias))
    else $error("IF section not restored after power-down clear");

  pd_effects_a: assert property (@(posedge clk) disable iff (!rstn)
    if_ctrl.powered_down |-> (if_ctrl.counter_load && if_ctrl.cp_hiz
                              && if_ctrl.lock_detect_reset && if_ctrl.input_debias))
    else $error("power-down side effect missing");

  pd_loading_a: assert property (@(posedge clk) disable iff (!rstn)
    (if_ctrl.powered_down && ld_rf_a) |=> ##1
      (rf_frac == $past(shift_q[RF_FRAC_LSB +: RF_FRAC_W], 2)))
    else $error("word not latched during IF power-down");

  polarity_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifc |=> ##1 (if_ctrl.pd_positive == $past(shift_q[IF_POLARITY_BIT], 2)))
    else $error("IF polarity not taken from bit seven");

  pump_current_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifc |=> ##1 (if_ctrl.cp_current == $past(shift_q[IF_CP_CUR_LSB +: IF_CP_CUR_W], 2)))
    else $error("IF pump current field wrong");

  resync_gate_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifc |=> ##1 (resync_enable == ($past(shift_q[IF_RESYNC_HI], 2)
      && $past(shift_q[IF_RESYNC_MID], 2) && $past(shift_q[IF_RESYNC_LO], 2))))
    else $error("resync enable not from bits 15 14 11");

  resync_start_a: assert property (@(posedge clk) disable iff (!rstn)
    (resync_trig && if_ref_d == 15'h0001 && resync_d) ##1 (ref_tick && resync_d)
      |=> resync_pulse)
    else $error("RF write did not start resync");

  single_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
    resync_pulse |=> !resync_pulse)
    else $error("resync pulse longer than one cycle");

  ifc_decode_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifc |=> (if_control_setup == $past(shift_q)))
    else $error("address 110 did not load IF control");

  no_disabled_a: assert property (@(posedge clk) disable iff (!rstn)
    (!resync_d ##1 !resync_d) |=> !resync_pulse)
    else $error("resync pulse while disabled");

  // Field loads reach the outputs two cycles after the strobe rise
  rf_int_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_rf_a |=> ##1 (rf_int == $past(shift_q[RF_INT_LSB +: RF_INT_W], 2)))
    else $error("RF integer value not loaded");

  rf_frac_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_rf_a |=> ##1 (rf_frac == $past(shift_q[RF_FRAC_LSB +: RF_FRAC_W], 2)))
    else $error("RF fraction not loaded");

  modulus_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_rf_b |=> ##1 (fractional_modulus == $past(shift_q[RF_MOD_LSB +: RF_MOD_W], 2)))
    else $error("fractional modulus not loaded");

  rf_ref_div_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_rf_b |=> ##1 (rf_ref_div == $past(shift_q[RF_R_LSB +: RF_R_W], 2)))
    else $error("RF reference divider not loaded");

  rf_doubler_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_rf_b |=> ##1 (rf_ref_doubler == $past(shift_q[RF_DBL_BIT], 2)))
    else $error("RF doubler not loaded");

  if_ref_div_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifr |=> ##1 (if_ref_div == $past(shift_q[IF_REF_LSB +: IF_REF_W], 2)))
    else $error("IF reference count not loaded");

  if_doubler_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifr |=> ##1 (if_ref_doubler == $past(shift_q[IF_DBL_BIT], 2)))
    else $error("IF doubler not loaded");

  if_n_total_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifn |=> ##1 (int'(if_n_total) == (8 << $past(shift_q[IF_P_LSB +: IF_P_W], 2))
      * $past(shift_q[IF_B_LSB +: IF_B_W], 2) + $past(shift_q[IF_A_LSB +: IF_A_W], 2)))
    else $error("IF total divide wrong");

  master_word_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_mst |=> ##1 (master_config_word == $past(shift_q, 2)))
    else $error("master word not latched");

  rf_control_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_rfc |=> ##1 (rf_control_word == $past(shift_q, 2)))
    else $error("RF control word not latched");

  counter_load_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifc |=> ##1 (if_ctrl.counter_load == ($past(shift_q[IF_CNT_RST_BIT], 2)
      || $past(shift_q[IF_PWR_DN_BIT], 2))))
    else $error("IF counters not in load state");

  addr_unused_a: assert property (@(posedge clk) disable iff (!rstn)
    (strobe_rise && addr == 3'h7) |=> (if_control_setup == $past(if_control_setup)))
    else $error("unused address changed a word");

  pd_enter_a: assert property (@(posedge clk) disable iff (!rstn)
    (ld_ifc && shift_q[IF_PWR_DN_BIT]) |=> ##1 if_ctrl.powered_down)
    else $error("IF section not powered down");

  pd_debias_a: assert property (@(posedge clk) disable iff (!rstn)
    (ld_ifc && shift_q[IF_PWR_DN_BIT]) |=> ##1
      (if_ctrl.lock_detect_reset && if_ctrl.input_debias && if_ctrl.counter_load))
    else $error("IF lock detect or input not reset");

  test_bits_a: assert property (@(posedge clk) disable iff (!rstn)
    ld_ifc |=> ##1 (if_ctrl.test_mode == $past(shift_q[IF_TEST_LSB +: IF_TEST_W], 2)))
    else $error("IF test bits not passed out");

  pd_write_c: cover property (@(posedge clk) disable iff (!rstn)
    ld_ifc && shift_q[IF_PWR_DN_BIT]);
  resync_trig_c: cover property (@(posedge clk) disable iff (!rstn)
    resync_trig);
  resync_pulse_c: cover property (@(posedge clk) disable iff (!rstn)
    resync_pulse);
  pd_rf_write_c: cover property (@(posedge clk) disable iff (!rstn)
    if_ctrl.powered_down && ld_rf_b);
  ifr_resync_c: cover property (@(posedge clk) disable iff (!rstn)
    ld_ifr && resync_d);

endmodule

// >>> sic_host_model.sv
// Host model that writes serial words into the synthesizer control block
`timescale 1ns/10ps
module sic_host_model
  import sic_pkg::*;
(
  input  wire logic            clk,
  output sic_pkg::sic_serial_t serial
);
  import sic_pkg::*;

  initial serial = '0;

  // One bit per serial clock rise; data scrambled once hold has passed
  task automatic shift_bit(input logic b);
    @(posedge clk);
    serial.sdata <= b;
    serial.sclk  <= 1'b1;
    @(posedge clk);
    serial.sclk  <= 1'b0;
    serial.sdata <= ~b;
  endtask

  // Strobe rises with serial clock already low
  task automatic strobe();
    @(posedge clk);
    serial.latch_strobe <= 1'b1;
    @(posedge clk);
    serial.latch_strobe <= 1'b0;
  endtask

  task automatic write_word(input logic [WORD_W-1:0] w);
    for (int i = WORD_W - 1; i >= 0; i--) shift_bit(w[i]);
    strobe();
  endtask

  // Over-long frame: leading bits must fall out of the shift word
  task automatic write_long(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) shift_bit(w[i]);
    strobe();
  endtask
endmodule

// >>> synth_if_control_and_resync_tb.sv
// Self-checking testbench of the synthesizer control block
`timescale 1ns/10ps
module synth_if_control_and_resync_tb;
  import sic_pkg::*;

  logic                    clk = 1'b0;
  logic                    rstn = 1'b0;
  logic                    reference_input = 1'b0;
  logic [1:0]              ref_cnt = 2'h0;
  sic_serial_t             serial;
  sic_if_ctrl_t            if_ctrl;
  logic                    resync_enable;
  logic                    resync_pulse;
  logic [RF_INT_W-1:0]     rf_int;
  logic [RF_FRAC_W-1:0]    rf_frac;
  logic [RF_MOD_W-1:0]     fractional_modulus;
  logic [RF_R_W-1:0]       rf_ref_div;
  logic                    rf_ref_doubler;
  logic [IF_REF_W-1:0]     if_ref_div;
  logic                    if_ref_doubler;
  logic [IF_N_W-1:0]       if_n_total;
  logic [WORD_W-1:0]       master_config_word;
  logic [WORD_W-1:0]       rf_control_word;
  logic                    ref_prev = 1'b0;
  logic                    stb_prev = 1'b0;
  logic [31:0]             ticks = '0;
  logic [31:0]             pulses = '0;
  logic [31:0]             tick_at_pulse = '0;
  int                      mismatches = 0;
  int                      cmp_count = 0;

  always #5 clk = ~clk;

  // Free-running reference, four clocks a period
  always @(posedge clk) begin
    ref_cnt <= ref_cnt + 2'h1;
    reference_input <= ref_cnt[1];
  end

  // Ticks since the last strobe rise, and resync pulses seen
  always @(posedge clk) begin
    ref_prev <= reference_input;
    stb_prev <= serial.latch_strobe;
    if (serial.latch_strobe && !stb_prev) begin
      ticks <= '0;
    end else if (reference_input && !ref_prev) begin
      ticks <= ticks + 32'h1;
    end
    if (resync_pulse === 1'b1) begin
      pulses <= pulses + 32'h1;
      tick_at_pulse <= ticks;
    end
  end

  sic_host_model host (.clk(clk), .serial(serial));

  sic_synth_ctrl dut (
    .clk(clk), .rstn(rstn), .serial(serial), .reference_input(reference_input),
    .if_ctrl(if_ctrl), .resync_enable(resync_enable), .resync_pulse(resync_pulse),
    .rf_int(rf_int), .rf_frac(rf_frac), .fractional_modulus(fractional_modulus),
    .rf_ref_div(rf_ref_div), .rf_ref_doubler(rf_ref_doubler), .if_ref_div(if_ref_div),
    .if_ref_doubler(if_ref_doubler), .if_n_total(if_n_total),
    .master_config_word(master_config_word), .rf_control_word(rf_control_word)
  );

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_ctrl(input sic_if_ctrl_t got, input sic_if_ctrl_t exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t if_ctrl got %h expected %h", $time, got, exp);
    end
  endtask

  // Outputs land two cycles after the strobe is seen
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  function automatic logic [WORD_W-1:0] ifc(input logic [2:0] rs, input logic pd,
                                            input logic hiz, input logic pol,
                                            input logic [2:0] cur);
    return {8'h00, rs[2], rs[1], 2'b00, rs[0], cur, pol, 1'b0, pd, hiz, 1'b0, 3'h6};
  endfunction

  function automatic sic_if_ctrl_t exp_ctrl(input logic [WORD_W-1:0] w);
    sic_if_ctrl_t e;
    e.cp_hiz = w[4] | w[5];
    e.counter_load = w[3] | w[5];
    e.lock_detect_reset = w[5];
    e.input_debias = w[5];
    e.powered_down = w[5];
    e.pd_positive = w[7];
    e.cp_current = w[10:8];
    e.test_mode = w[13:12];
    return e;
  endfunction

  task automatic t_reset();
    chk_ctrl(if_ctrl, '0);
    chk_val({20'h0, rf_ref_div, rf_int}, 32'h0);
    chk_val({8'h0, master_config_word}, 32'h0);
    chk_val({31'h0, resync_pulse}, 32'h0);
  endtask

  task automatic t_ifctrl();
    logic [WORD_W-1:0] w;
    for (int c = 7; c >= 0; c--) begin
      w = ifc(3'h0, 1'b0, c[0], c[1], c[2:0]);
      host.write_word(w);
      settle();
      chk_ctrl(if_ctrl, exp_ctrl(w));
    end
    host.write_word(24'hffffff);
    settle();
    chk_ctrl(if_ctrl, exp_ctrl(w));
  endtask

  task automatic t_rf_only_pd();
    host.write_word(24'h000026);
    host.write_word({21'h0, ADDR_IF_REF_DIV});
    host.write_word({21'h0, ADDR_IF_N_DIV});
    settle();
    chk_ctrl(if_ctrl, exp_ctrl(24'h000026));
    host.write_word({1'b0, 8'd138, 12'd30, ADDR_RF_FREQ_A});
    host.write_word({4'h0, 1'b1, 4'hf, 12'hfff, ADDR_RF_FREQ_B});
    settle();
    chk_val({12'h0, rf_int, rf_frac}, {12'h0, 8'd138, 12'd30});
    chk_val({15'h0, rf_ref_doubler, rf_ref_div, fractional_modulus}, 32'h1ffff);
    host.write_word(ifc(3'h0, 1'b0, 1'b0, 1'b1, 3'h2));
    settle();
    chk_ctrl(if_ctrl, exp_ctrl(ifc(3'h0, 1'b0, 1'b0, 1'b1, 3'h2)));
    chk_val({24'h0, rf_int}, 32'd138);
  endtask

  task automatic t_if_only();
    logic [31:0] n;
    host.write_word(24'h000023);
    host.write_word({21'h0, ADDR_RF_CONTROL});
    host.write_word({5'h0, 1'b0, 15'd65, ADDR_IF_REF_DIV});
    settle();
    chk_val({8'h0, master_config_word}, 32'h23);
    chk_val({8'h0, rf_control_word}, 32'h2);
    chk_val({16'h0, if_ref_doubler, if_ref_div}, 32'd65);
    for (int p = 0; p < 4; p++) begin
      host.write_word({1'b0, p[1:0], 12'd168, 6'd12, ADDR_IF_N_DIV});
      settle();
      n = (32'd8 << p) * 32'd168 + 32'd12;
      chk_val({13'h0, if_n_total}, n);
    end
  endtask

  task automatic t_long_frame();
    logic [WORD_W-1:0] w;
    w = ifc(3'h0, 1'b0, 1'b1, 1'b0, 3'h5);
    host.write_long({8'hff, w});
    settle();
    chk_ctrl(if_ctrl, exp_ctrl(w));
  endtask

  task automatic t_resync();
    logic [31:0] base;
    int n;
    host.write_word({4'h0, 1'b0, 4'h1, 12'd5, ADDR_RF_FREQ_B});
    host.write_word({5'h0, 1'b0, 15'd10, ADDR_IF_REF_DIV});
    for (int r = 0; r < 8; r++) begin
      host.write_word(ifc(r[2:0], 1'b0, 1'b0, 1'b1, 3'h0));
      settle();
      chk_val({31'h0, resync_enable}, {31'h0, r == 7});
    end
    host.write_word(ifc(3'h3, 1'b0, 1'b0, 1'b1, 3'h0));
    base = pulses;
    host.write_word({1'b0, 8'd100, 12'd1, ADDR_RF_FREQ_A});
    repeat (80) @(posedge clk);
    #1;
    chk_val(pulses, base);
    host.write_word(ifc(3'h7, 1'b0, 1'b0, 1'b1, 3'h0));
    settle();
    for (int k = 0; k < 2; k++) begin
      base = pulses;
      host.write_word(k == 0 ? {1'b0, 8'd101, 12'd2, ADDR_RF_FREQ_A} :
                               {4'h0, 1'b0, 4'h1, 12'd5, ADDR_RF_FREQ_B});
      n = 0;
      while (pulses === base && n < 200) begin
        @(posedge clk);
        n++;
      end
      if (n >= 200) begin
        mismatches++;
        $display("[ERR] %0t no resync pulse", $time);
        finish_test();
      end
      repeat (60) @(posedge clk);
      #1;
      chk_val(pulses - base, 32'h1);
      chk_val(tick_at_pulse, 32'd10);
    end
    // Shortest delay; 63 cycles a round walks the trigger through all reference phases
    host.write_word({5'h0, 1'b0, 15'd1, ADDR_IF_REF_DIV});
    for (int j = 0; j < 4; j++) begin
      base = pulses;
      host.write_word({4'h0, 1'b0, 4'h1, 12'd1, ADDR_RF_FREQ_B});
      repeat (13) @(posedge clk);
      #1;
      chk_val(pulses - base, 32'h1);
      chk_val(tick_at_pulse, 32'd1);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    t_reset();
    t_ifctrl();
    t_rf_only_pd();
    t_if_only();
    t_long_frame();
    t_resync();
    finish_test();
  end
endmodule
